// ==== verilog/nvtc_top.sv ====
// Behaviour
// - recall input low while idle and busy low starts a hardware recall, latches ignored
// - store finishes within 5 ms after clock 8 of the store instruction
// - serial output released to high impedance within 500 ns of recall
// - automatic store on supply loss completes within 5 ms
// - power-up clears write-enable and auto-store-enable latches
// - prior-recall set only by recall; store needs it and write-enable
// - power-up recall leaves prior-recall clear; commands ignored meanwhile
//
// Purpose: sequences recall and store transfers of the shadow memory
// Assumes: serial decoding done outside; cmd pulses arrive after clock 8
// Notes: supply-low comes from an analog detector outside this block
`timescale 1ns/1ps
module nvtc_top #(
    parameter int unsigned STORE_CYCLES = nvtc_pkg::STORE_CYCLES,
    parameter int unsigned AUTO_STORE_CYCLES = nvtc_pkg::AUTO_STORE_CYCLES,
    parameter int unsigned POWERUP_READ_CYCLES =
        nvtc_pkg::POWERUP_READ_CYCLES,
    parameter int unsigned POWERUP_WRITE_CYCLES =
        nvtc_pkg::POWERUP_WRITE_CYCLES
) (
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire nvtc_pkg::nvtc_cmd_t CMD_I,
    input wire logic RECALL_N_I,
    input wire logic SUPPLY_LOW_I,
    output nvtc_pkg::nvtc_xfer_t XFER_O,
    output logic SO_FLOAT_O,
    output logic WRITE_ENABLE_O,
    output logic AUTO_STORE_ENABLE_O,
    output logic PRIOR_RECALL_O,
    output logic READ_OK_O,
    output logic WRITE_OK_O,
    output logic CMD_ACCEPT_O
);
    import nvtc_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    nvtc_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] pwr_reg, pwr_next;
    logic wel_reg, wel_next;
    logic asel_reg, asel_next;
    logic prl_reg, prl_next;
    logic float_reg, float_next;
    logic done_reg, done_next;
    logic rdok_reg, rdok_next;
    logic wrok_reg, wrok_next;

    function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
        cyc = CNT_W'(n - 1);
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        pwr_next = pwr_reg;
        wel_next = wel_reg;
        asel_next = asel_reg;
        prl_next = prl_reg;
        float_next = float_reg;
        done_next = 1'b0;
        rdok_next = rdok_reg;
        wrok_next = wrok_reg;

        // power-up delay windows
        if (pwr_reg != cyc(POWERUP_WRITE_CYCLES)) begin
            pwr_next = pwr_reg + CNT_W'(1);
        end
        if (pwr_reg >= cyc(POWERUP_READ_CYCLES)) begin
            rdok_next = 1'b1;
        end
        if (pwr_reg == cyc(POWERUP_WRITE_CYCLES)) begin
            wrok_next = 1'b1;
        end

        // supply loss with auto-store enabled overrides everything that runs on the array
        if (SUPPLY_LOW_I && asel_reg && state_reg != NVTC_AUTO_STORE &&
            state_reg != NVTC_HALTED) begin
            state_next = NVTC_AUTO_STORE;
            cnt_next = cyc(AUTO_STORE_CYCLES);
        end else begin
            unique case (state_reg)
                NVTC_PWR_RECALL: begin
                    // commands are dropped here, prior-recall stays clear
                    float_next = 1'b1;
                    if (cnt_reg == '0) begin
                        state_next = NVTC_IDLE;
                        float_next = 1'b0;
                        done_next = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - CNT_W'(1);
                    end
                end
                NVTC_IDLE: begin
                    if (!RECALL_N_I && !CMD_I.busy) begin
                        state_next = NVTC_RECALL;
                        cnt_next = cyc(RECALL_CYCLES);
                        float_next = 1'b1;
                    end else if (CMD_I.recall_instruction && RECALL_N_I) begin
                        state_next = NVTC_RECALL;
                        cnt_next = cyc(RECALL_CYCLES);
                        float_next = 1'b1;
                    end else if (CMD_I.store_instruction && RECALL_N_I &&
                                 wel_reg && prl_reg) begin
                        state_next = NVTC_STORE;
                        cnt_next = cyc(STORE_CYCLES);
                    end else begin
                        if (CMD_I.set_write_enable) begin
                            wel_next = 1'b1;
                        end else if (CMD_I.clr_write_enable) begin
                            wel_next = 1'b0;
                        end
                        if (CMD_I.set_auto_store_enable) begin
                            asel_next = 1'b1;
                        end else if (CMD_I.clr_auto_store_enable) begin
                            asel_next = 1'b0;
                        end
                    end
                end
                NVTC_RECALL: begin
                    if (cnt_reg == '0) begin
                        state_next = NVTC_IDLE;
                        prl_next = 1'b1;
                        float_next = 1'b0;
                        done_next = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - CNT_W'(1);
                    end
                end
                NVTC_STORE: begin
                    if (cnt_reg == '0) begin
                        state_next = NVTC_IDLE;
                        done_next = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - CNT_W'(1);
                    end
                end
                NVTC_AUTO_STORE: begin
                    if (cnt_reg == '0) begin
                        // supply is going away; wait for reset
                        state_next = NVTC_HALTED;
                        done_next = 1'b1;
                    end else begin
                        cnt_next = cnt_reg - CNT_W'(1);
                    end
                end
                NVTC_HALTED: begin
                    state_next = NVTC_HALTED;
                end
                default: begin
                    state_next = NVTC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            state_reg <= NVTC_PWR_RECALL;
            cnt_reg <= CNT_W'(RECALL_CYCLES - 1);
            pwr_reg <= '0;
            wel_reg <= 1'b0;
            asel_reg <= 1'b0;
            prl_reg <= 1'b0;
            float_reg <= 1'b1;
            done_reg <= 1'b0;
            rdok_reg <= 1'b0;
            wrok_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pwr_reg <= pwr_next;
            wel_reg <= wel_next;
            asel_reg <= asel_next;
            prl_reg <= prl_next;
            float_reg <= float_next;
            done_reg <= done_next;
            rdok_reg <= rdok_next;
            wrok_reg <= wrok_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic rcl_act_reg, rcl_act_next;
    logic sto_act_reg, sto_act_next;
    logic acc_reg, acc_next;

    always_comb begin
        rcl_act_next = (state_next == NVTC_RECALL) ||
                       (state_next == NVTC_PWR_RECALL);
        sto_act_next = (state_next == NVTC_STORE) ||
                       (state_next == NVTC_AUTO_STORE);
        // built from next values so the flop matches the live idle state
        acc_next = rdok_next && (state_next == NVTC_IDLE);
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!NRST_I) begin
            rcl_act_reg <= 1'b1;
            sto_act_reg <= 1'b0;
            acc_reg <= 1'b0;
        end else begin
            rcl_act_reg <= rcl_act_next;
            sto_act_reg <= sto_act_next;
            acc_reg <= acc_next;
        end
    end

    assign XFER_O = '{recall_active: rcl_act_reg,
                      store_active: sto_act_reg,
                      done: done_reg};
    assign SO_FLOAT_O = float_reg;
    assign WRITE_ENABLE_O = wel_reg;
    assign AUTO_STORE_ENABLE_O = asel_reg;
    assign PRIOR_RECALL_O = prl_reg;
    assign READ_OK_O = rdok_reg;
    assign WRITE_OK_O = wrok_reg;
    assign CMD_ACCEPT_O = acc_reg;

endmodule // nvtc_top

// ==== verilog/nvtc_pkg.sv ====
// Purpose: shared constants and types for the nonvolatile transfer control
// Assumes: 125 MHz system clock
// Notes: times kept in their own units, cycle counts derived from them
package nvtc_pkg;

    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned CLK_PERIOD_NS = 8;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned POWERUP_READ_DELAY_US = 200;
    localparam int unsigned POWERUP_WRITE_DELAY_MS = 5;
    localparam int unsigned STORE_COMPLETION_TIME_MS = 5;
    localparam int unsigned STORE_TYPICAL_TIME_MS = 2;
    localparam int unsigned AUTO_STORE_CYCLE_TIME_MS = 5;
    localparam int unsigned RECALL_OUTPUT_FLOAT_TIME_NS = 500;
    localparam int unsigned RECALL_CYCLE_TIME_US = 2;
    localparam int unsigned STORE_CLOCK_COUNT = 8;

    // longest times round down, least times round up
    localparam int unsigned POWERUP_READ_CYCLES =
        POWERUP_READ_DELAY_US * CLK_MHZ;
    localparam int unsigned POWERUP_WRITE_CYCLES =
        POWERUP_WRITE_DELAY_MS * 1000 * CLK_MHZ;
    localparam int unsigned STORE_CYCLES =
        STORE_TYPICAL_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned STORE_MAX_CYCLES =
        STORE_COMPLETION_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned AUTO_STORE_CYCLES =
        AUTO_STORE_CYCLE_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned RECALL_CYCLES =
        (RECALL_CYCLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FLOAT_CYCLES =
        RECALL_OUTPUT_FLOAT_TIME_NS / CLK_PERIOD_NS;

    localparam int unsigned CNT_W = 24;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        NVTC_PWR_RECALL = 3'b000,
        NVTC_IDLE = 3'b001,
        NVTC_RECALL = 3'b010,
        NVTC_STORE = 3'b011,
        NVTC_AUTO_STORE = 3'b100,
        NVTC_HALTED = 3'b101
    } nvtc_state_t;

    // one instruction from the serial decoder, pulse per field except busy, which is held as a level
    typedef struct packed {
        logic recall_instruction;
        logic store_instruction;
        logic set_write_enable;
        logic clr_write_enable;
        logic set_auto_store_enable;
        logic clr_auto_store_enable;
        logic busy;
    } nvtc_cmd_t;

    // transfer strobes toward the memory arrays
    typedef struct packed {
        logic recall_active;
        logic store_active;
        logic done;
    } nvtc_xfer_t;

endpackage

// ==== testbench/nvtc_chk.sv ====
// Purpose: port checker for the transfer control
// Assumes: bound to nvtc_top, one clock domain
// Notes: store runs bounded by the longer of the two store counts
`timescale 1ns/1ps
module nvtc_chk import nvtc_pkg::*; #(
    parameter int unsigned STORE_CYCLES = 20,
    parameter int unsigned AUTO_STORE_CYCLES = 20
) (
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    input wire nvtc_pkg::nvtc_cmd_t CMD_I,
    input wire logic RECALL_N_I,
    input wire logic SUPPLY_LOW_I,
    input wire nvtc_pkg::nvtc_xfer_t XFER_O,
    input wire logic SO_FLOAT_O,
    input wire logic WRITE_ENABLE_O,
    input wire logic AUTO_STORE_ENABLE_O,
    input wire logic PRIOR_RECALL_O,
    input wire logic WRITE_OK_O,
    input wire logic CMD_ACCEPT_O
);
    localparam int unsigned LIM = STORE_CYCLES > AUTO_STORE_CYCLES ?
        STORE_CYCLES : AUTO_STORE_CYCLES;
    logic [23:0] run_reg;
    logic [23:0] run_next;
    always_comb run_next = XFER_O.store_active ? run_reg + 24'h1 : 24'h0;
    always_ff @(posedge SYS_CLK_I) run_reg <= NRST_I ? run_next : 24'h0;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);
    sequence s_rcl_go;
        ##[1:2] XFER_O.recall_active && SO_FLOAT_O;
    endsequence
    property p_float; XFER_O.recall_active |-> SO_FLOAT_O; endproperty
    a_float: assert property (p_float) else $error("not floated");
    property p_hw; CMD_ACCEPT_O && !RECALL_N_I && !CMD_I.busy &&
        !SUPPLY_LOW_I |-> s_rcl_go; endproperty
    a_hw: assert property (p_hw) else $error("pin recall lost");
    property p_sw; CMD_ACCEPT_O && RECALL_N_I && CMD_I.recall_instruction
        && !SUPPLY_LOW_I |-> s_rcl_go; endproperty
    a_sw: assert property (p_sw) else $error("recall lost");
    property p_sto; CMD_ACCEPT_O && RECALL_N_I && CMD_I.store_instruction
        && WRITE_ENABLE_O && PRIOR_RECALL_O && WRITE_OK_O
        |-> ##[1:2] XFER_O.store_active; endproperty
    a_sto: assert property (p_sto) else $error("store lost");
    property p_run; run_reg <= LIM; endproperty
    a_run: assert property (p_run) else $error("store too long");
    property p_prior; $rose(PRIOR_RECALL_O) |->
        $past(XFER_O.recall_active) && XFER_O.done; endproperty
    a_prior: assert property (p_prior) else $error("stray prior");
    property p_pwr; $rose(NRST_I) |-> !(WRITE_ENABLE_O ||
        AUTO_STORE_ENABLE_O || PRIOR_RECALL_O); endproperty
    a_pwr: assert property (p_pwr) else $error("latch set");
    property p_auto; $rose(SUPPLY_LOW_I) && AUTO_STORE_ENABLE_O
        |-> ##[1:2] XFER_O.store_active; endproperty
    a_auto: assert property (p_auto) else $error("no auto store");
endmodule // nvtc_chk
bind nvtc_top nvtc_chk #(.STORE_CYCLES(STORE_CYCLES),
    .AUTO_STORE_CYCLES(AUTO_STORE_CYCLES)) u_chk (.SYS_CLK_I(SYS_CLK_I),
    .NRST_I(NRST_I), .CMD_I(CMD_I), .RECALL_N_I(RECALL_N_I),
    .SUPPLY_LOW_I(SUPPLY_LOW_I), .XFER_O(XFER_O), .SO_FLOAT_O(SO_FLOAT_O),
    .WRITE_ENABLE_O(WRITE_ENABLE_O), .AUTO_STORE_ENABLE_O(AUTO_STORE_ENABLE_O),
    .PRIOR_RECALL_O(PRIOR_RECALL_O), .WRITE_OK_O(WRITE_OK_O),
    .CMD_ACCEPT_O(CMD_ACCEPT_O));

// ==== testbench/nvtc_host.sv ====
// Purpose: host model driving instructions and the recall pin
// Assumes: one instruction at a time
// Notes: power-up waits follow the ok flags
`timescale 1ns/1ps
module nvtc_host import nvtc_pkg::*; (
    input wire logic SYS_CLK_I,
    input wire logic READ_OK_I,
    input wire logic WRITE_OK_I,
    output nvtc_pkg::nvtc_cmd_t CMD_O,
    output logic RECALL_N_O
);
    // 500 ns minimum recall pulse in 8 ns cycles
    localparam int PULSE = 63;
    initial CMD_O = '0;
    initial RECALL_N_O = 1'b1;
    task automatic send(input nvtc_cmd_t c, input bit wr);
        wait (READ_OK_I);
        if (wr)
            wait (WRITE_OK_I);
        @(posedge SYS_CLK_I) #1;
        CMD_O = c;
        @(posedge SYS_CLK_I) #1;
        CMD_O = '0;
    endtask
    task automatic busy(input logic v);
        @(posedge SYS_CLK_I) #1;
        CMD_O.busy = v;
    endtask
    // released after the minimum pulse so recall does not run twice
    task automatic hw;
        @(posedge SYS_CLK_I) #1;
        RECALL_N_O = 1'b0;
        fork
            begin
                repeat (PULSE) @(posedge SYS_CLK_I);
                #1 RECALL_N_O = 1'b1;
            end
        join_none
    endtask
endmodule // nvtc_host

// ==== testbench/nvtc_top_tb.sv ====
// Purpose: scenario bench for the transfer control
// Assumes: shortened power-up and store counts
// Notes: recall length stays at its full count
`timescale 1ns/1ps
module nvtc_top_tb import nvtc_pkg::*; ;
    localparam int unsigned ST = 20;
    localparam int unsigned AS = 20;
    localparam int unsigned RD = 10;
    localparam int unsigned WR = 30;
    localparam nvtc_cmd_t CAS = 7'h02;
    localparam nvtc_cmd_t RECALL_INSTRUCTION = 7'h40;
    localparam nvtc_cmd_t STORE_INSTRUCTION = 7'h20;
    localparam nvtc_cmd_t SWE = 7'h10;
    localparam nvtc_cmd_t CWE = 7'h08;
    localparam nvtc_cmd_t SAS = 7'h04;
    logic sys_clk, nrst, supply_low, rcl_n, flt, we, ase, pr, rok, wok, acc;
    nvtc_cmd_t cmd;
    nvtc_xfer_t xfer;
    int mismatches = 0;
    int cmp_count = 0;
    int len;
    always #4 sys_clk = ~sys_clk;
    nvtc_top #(.STORE_CYCLES(ST), .AUTO_STORE_CYCLES(AS),
        .POWERUP_READ_CYCLES(RD), .POWERUP_WRITE_CYCLES(WR)) dut (
        .SYS_CLK_I(sys_clk), .NRST_I(nrst), .CMD_I(cmd), .RECALL_N_I(rcl_n),
        .SUPPLY_LOW_I(supply_low), .XFER_O(xfer), .SO_FLOAT_O(flt),
        .WRITE_ENABLE_O(we), .AUTO_STORE_ENABLE_O(ase), .PRIOR_RECALL_O(pr),
        .READ_OK_O(rok), .WRITE_OK_O(wok), .CMD_ACCEPT_O(acc));
    nvtc_host host (.SYS_CLK_I(sys_clk), .READ_OK_I(rok), .WRITE_OK_I(wok),
        .CMD_O(cmd), .RECALL_N_O(rcl_n));
    task automatic chk(input logic got, input logic exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk) #1;
    endtask
    // counts the transfer now starting, then expects its end pulse
    task automatic span(output int n);
        n = 0;
        repeat (2) if (!(xfer.recall_active || xfer.store_active)) tick(1);
        while ((xfer.recall_active || xfer.store_active) && n < 999) begin
            if (xfer.recall_active) chk(flt, 1'b1, "float");
            n++;
            tick(1);
        end
        chk(xfer.done, 1'b1, "done");
    endtask
    task automatic do_reset;
        nrst = 1'b0;
        tick(6);
        chk(flt & xfer.recall_active, 1'b1, "reset state");
        chk(we | ase | pr, 1'b0, "latches");
        nrst = 1'b1;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_power;
        do_reset();
        tick(RD - 1);
        chk(rok, 1'b0, "read window early");
        tick(1);
        chk(rok, 1'b1, "read window");
        tick(WR - RD - 1);
        chk(wok, 1'b0, "write window early");
        tick(1);
        chk(wok, 1'b1, "write window");
        host.send(SWE, 1'b0);
        span(len);
        chk(we | pr, 1'b0, "ignored");
    endtask
    task automatic t_refuse;
        host.send(SWE, 1'b0);
        tick(1);
        chk(we, 1'b1, "write enable");
        host.send(STORE_INSTRUCTION, 1'b1);
        tick(2);
        chk(xfer.store_active, 1'b0, "store refused");
        host.send(SAS, 1'b0);
        tick(1);
        chk(ase, 1'b1, "auto enable set");
        host.send(CAS, 1'b0);
        tick(1);
        chk(ase, 1'b0, "auto enable clear");
        supply_low = 1'b1;
        tick(3);
        chk(xfer.store_active, 1'b0, "auto store disabled");
        supply_low = 1'b0;
    endtask
    task automatic t_sw_recall;
        host.send(RECALL_INSTRUCTION, 1'b0);
        span(len);
        chk(len == RECALL_CYCLES, 1'b1, "recall length");
        chk(pr & !flt, 1'b1, "after recall");
    endtask
    task automatic t_store;
        host.send(STORE_INSTRUCTION, 1'b1);
        span(len);
        chk(len == ST, 1'b1, "store length");
    endtask
    task automatic t_hw_recall;
        host.send(CWE, 1'b0);
        host.send(STORE_INSTRUCTION, 1'b1);
        tick(2);
        chk(xfer.store_active, 1'b0, "store needs write enable");
        host.busy(1'b1);
        host.hw();
        tick(70);
        chk(xfer.recall_active, 1'b0, "busy blocks");
        host.busy(1'b0);
        host.hw();
        span(len);
        chk(len == RECALL_CYCLES, 1'b1, "pin recall");
    endtask
    task automatic t_auto;
        host.send(SAS, 1'b0);
        tick(1);
        supply_low = 1'b1;
        span(len);
        chk(len == AS, 1'b1, "auto length");
        tick(3);
        chk(acc | xfer.store_active, 1'b0, "halted");
        supply_low = 1'b0;
        do_reset();
        span(len);
    endtask
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        supply_low = 1'b0;
        t_power();
        t_refuse();
        t_sw_recall();
        t_store();
        t_hw_recall();
        t_auto();
        close_out();
    end
    initial begin
        #200000;
        mismatches++;
        close_out();
    end
endmodule // nvtc_top_tb
